/* File: logic/adcseq_pkg.sv */
package adcseq_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_TIMING  = 8'h00;
  localparam logic [7:0] ADDR_CHANCTL = 8'h04;
  localparam logic [7:0] ADDR_CALCTL  = 8'h08;
  localparam logic [7:0] ADDR_CALOFS  = 8'h0c;
  localparam logic [7:0] ADDR_CALGAIN = 8'h10;
  localparam logic [7:0] ADDR_RESULT  = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;

  // adc_timing_trigger_config fields
  localparam int TT_EXT_BIT = 0;
  localparam int TT_TMR_BIT = 1;
  localparam int TT_ACQ_LSB = 2;
  localparam int TT_DIV_LSB = 4;
  // adc_channel_start_control fields
  localparam int CS_CH_LSB     = 0;
  localparam int CS_CONT_BIT   = 4;
  localparam int CS_SINGLE_BIT = 5;
  localparam int CS_CAP_BIT    = 6;
  // adc_calibration_control fields
  localparam int CAL_START_BIT = 0;
  localparam int CAL_BUSY_BIT  = 7;
  // status fields
  localparam int ST_DONE_BIT = 0;
  localparam int ST_LOST_BIT = 1;
  localparam int ST_BUSY_BIT = 2;

  // reset values
  localparam logic [7:0]  TT_RST   = 8'h00;
  localparam logic [7:0]  CS_RST   = 8'h00;
  localparam logic [13:0] COEF_RST = 14'h0000;

  // timing
  localparam int          CLK_MHZ           = 200;
  localparam logic [3:0]  CONV_PERIODS      = 4'hf;
  localparam logic [3:0]  CONV_LAST         = CONV_PERIODS - 4'h1;
  localparam logic [3:0]  TEMP_CHANNEL      = 4'h8;
  localparam logic [1:0]  TEMP_DIV_SEL      = 2'h3;
  localparam logic [1:0]  TEMP_ACQ_SEL      = 2'h3;
  localparam int          CAL_CNT_W         = 11;
  localparam logic [10:0] CAL_CYCLES        = 11'h400;
  localparam logic [3:0]  SER_HALF_CYCLES   = 4'h2;
  localparam int          STROBE_LOW_NS     = 100;
  localparam int          STROBE_LOW_CYCLES = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_ACQ, ST_CONV} adcseq_state_t;

  function automatic logic [5:0] adcseq_div_ratio(input logic [1:0] sel);
    case (sel)
      2'h0:    return 6'h08;
      2'h1:    return 6'h04;
      2'h2:    return 6'h10;
      default: return 6'h20;
    endcase
  endfunction

  function automatic logic [31:0] adcseq_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return m;
  endfunction

endpackage

/* File: logic/adcseq_shift.sv */
`timescale 1ns/1ps
module adcseq_shift
  import adcseq_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        load,
  input  wire logic [15:0] data,
  output logic             busy,
  output logic             sclk,
  output logic             mosi,
  output logic             frame_n
);

  typedef struct packed {
    logic [15:0] sdr;
    logic [3:0]  bit_cnt;
    logic [3:0]  half;
    logic        active;
    logic        sclk;
    logic        mosi;
    logic        frame_n;
  } adcseq_shift_t;

  adcseq_shift_t r;
  adcseq_shift_t n;

  always_comb begin
    n = r;
    if (!enable) begin
      // dropping the enable abandons a word mid-frame
      n.active  = 1'b0;
      n.sclk    = 1'b0;
      n.frame_n = 1'b1;
      n.half    = 4'h0;
    end else if (!r.active) begin
      if (load) begin
        n.sdr     = data;
        n.active  = 1'b1;
        n.frame_n = 1'b0;
        n.bit_cnt = 4'h0;
        n.half    = 4'h0;
        n.mosi    = data[15]; // channel id leads, msb first
        n.sclk    = 1'b0;
      end
    end else if (r.half == SER_HALF_CYCLES - 4'h1) begin
      n.half = 4'h0;
      if (!r.sclk) begin
        n.sclk = 1'b1;
      end else begin
        n.sclk = 1'b0;
        if (r.bit_cnt == 4'hf) begin
          n.active  = 1'b0;
          n.frame_n = 1'b1;
        end else begin
          n.bit_cnt = r.bit_cnt + 4'h1;
          n.sdr     = {r.sdr[14:0], 1'b0};
          n.mosi    = r.sdr[14];
        end
      end
    end else begin
      n.half = r.half + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{sdr: 16'h0000, bit_cnt: 4'h0, half: 4'h0, active: 1'b0,
             sclk: 1'b0, mosi: 1'b0, frame_n: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign busy    = r.active;
  assign sclk    = r.sclk;
  assign mosi    = r.mosi;
  assign frame_n = r.frame_n;

endmodule // adcseq_shift

/* File: logic/adcseq_top.sv */
`timescale 1ns/1ps
// What this block does
// - converter clock divides core by 8/4/16/32
// - acquisition lasts 1 to 4 converter periods
// - conversion takes exactly fifteen converter periods
// - start synchronised, half to one-and-half periods
// - temperature channel forces divide 32, four periods
// - single request converts once, then self-clears
// - continuous bit runs back-to-back conversions until cleared
// - strobe rising edge starts conversion when enabled
// - timer two overflow starts conversion when enabled
// - capture mode moves results to serial data register
// - serial shift ends before next conversion ends, except at divide 4 with one-period acquisition
// - shift channel id then 12-bit value, msb first
// - capture mode disables serial port and port three
// - clearing capture restores ports, stops transfers
// - reset loads factory coefficients into calibration registers
// - busy flag high throughout calibration cycle
module adcseq_top
  import adcseq_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        external_convert_strobe_n,
  input  wire logic        timer2_overflow,
  input  wire logic [11:0] conv_data,
  input  wire logic [13:0] nv_offset_coef,
  input  wire logic [13:0] nv_gain_coef,
  output logic             converter_clock,
  output logic             conv_sample,
  output logic             conv_hold,
  output logic [3:0]       conv_channel,
  output logic             cal_active,
  output logic [13:0]      cal_offset,
  output logic [13:0]      cal_gain,
  output logic             serial_normal_disable,
  output logic             port3_disable,
  output logic             serial_sclk,
  output logic             serial_mosi,
  output logic             serial_frame_n
);

  typedef struct packed {
    adcseq_state_t        st;
    logic [7:0]           tt;
    logic [7:0]           cs;
    logic                 cal_start;
    logic [CAL_CNT_W-1:0] cal_cnt;
    logic                 nv_load;
    logic [13:0]          ofs;
    logic [13:0]          gain;
    logic [11:0]          res;
    logic [3:0]           res_ch;
    logic                 done;
    logic                 lost;
    logic [5:0]           div_cnt;
    logic                 cclk;
    logic                 armed;
    logic [3:0]           ph_cnt;
    logic [3:0]           ch;
    logic                 sample;
    logic                 hold;
    logic                 ext_s1;
    logic                 ext_s2;
    logic                 ext_s3;
    logic                 cap_load;
    logic [15:0]          cap_data;
    logic                 cap_dis;
    logic                 aw_have;
    logic [7:0]           aw_addr;
    logic                 w_have;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } adcseq_regs_t;

  adcseq_regs_t r;
  adcseq_regs_t n;

  logic        shift_busy;
  logic [1:0]  eff_div;
  logic [1:0]  eff_acq;
  logic [5:0]  ratio;
  logic        rise_tick;
  logic        fall_tick;
  logic        ext_rise;
  logic        start_req;
  logic        wr_go;
  logic        wr_hit;
  logic        wr_single;
  logic [31:0] wm;
  logic [32:0] rd;

  // {hit, word} for any register offset
  function automatic logic [32:0] reg_read(input logic [7:0] a);
    case (a)
      ADDR_TIMING:  return {1'b1, 24'h000000, r.tt};
      ADDR_CHANCTL: return {1'b1, 24'h000000, r.cs};
      ADDR_CALCTL:  return {1'b1, 24'h000000, r.cal_start | r.nv_load,
                            6'h00, r.cal_start};
      ADDR_CALOFS:  return {1'b1, 18'h00000, r.ofs};
      ADDR_CALGAIN: return {1'b1, 18'h00000, r.gain};
      ADDR_RESULT:  return {1'b1, 16'h0000, r.res_ch, r.res};
      ADDR_STATUS:  return {1'b1, 29'h00000000, r.st != ST_IDLE,
                            r.lost, r.done};
      default:      return {1'b0, 32'h00000000};
    endcase
  endfunction

  always_comb begin
    n          = r;
    n.cap_load = 1'b0;
    wr_hit     = 1'b0;
    wr_single  = 1'b0;
    wm         = 32'h00000000;
    rd         = reg_read(s_axi_araddr);

    // strobe pin: second and third stages feed the edge detector only
    n.ext_s1 = external_convert_strobe_n;
    n.ext_s2 = r.ext_s1;
    n.ext_s3 = r.ext_s2;
    ext_rise = r.ext_s2 & ~r.ext_s3;

    // temperature channel overrides programmed timing
    if (r.cs[CS_CH_LSB +: 4] == TEMP_CHANNEL) begin
      eff_div = TEMP_DIV_SEL;
      eff_acq = TEMP_ACQ_SEL;
    end else begin
      eff_div = r.tt[TT_DIV_LSB +: 2];
      eff_acq = r.tt[TT_ACQ_LSB +: 2];
    end

    // >= keeps the divider bounded when the ratio shrinks mid-count
    ratio     = adcseq_div_ratio(eff_div);
    rise_tick = (r.div_cnt >= ratio - 6'h01);
    fall_tick = (r.div_cnt == (ratio >> 1) - 6'h01);
    n.div_cnt = rise_tick ? 6'h00 : r.div_cnt + 6'h01;
    if (rise_tick) begin
      n.cclk = 1'b1;
    end else if (fall_tick) begin
      n.cclk = 1'b0;
    end

    // axi write: address and data taken in either order
    if (s_axi_awvalid && r.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_have = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
    wr_go = n.aw_have && n.w_have && !r.bvalid;
    if (wr_go) begin
      {wr_hit, wm} = reg_read(n.aw_addr);
      wm           = adcseq_merge(wm, n.w_data, n.w_strb);
      n.aw_have    = 1'b0;
      n.w_have     = 1'b0;
      n.bvalid     = 1'b1;
      n.bresp      = wr_hit ? RESP_OKAY : RESP_SLVERR;
      case (n.aw_addr)
        ADDR_TIMING: n.tt = wm[7:0];
        ADDR_CHANCTL: begin
          n.cs      = wm[7:0];
          wr_single = wm[CS_SINGLE_BIT];
        end
        ADDR_CALCTL: begin
          if (wm[CAL_START_BIT]) n.cal_start = 1'b1;
        end
        ADDR_CALOFS:  n.ofs = wm[13:0];
        ADDR_CALGAIN: n.gain = wm[13:0];
        ADDR_STATUS: begin
          // write one to clear; hardware sets below win
          if (n.w_strb[0] && n.w_data[ST_DONE_BIT]) n.done = 1'b0;
          if (n.w_strb[0] && n.w_data[ST_LOST_BIT]) n.lost = 1'b0;
        end
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready  = !n.w_have && !n.bvalid;

    // axi read: one outstanding, data registered
    if (s_axi_arvalid && r.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rdata   = rd[31:0];
      n.rresp   = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end
    if (r.rvalid && s_axi_rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end

    // factory coefficients copied on the first edge after reset
    if (r.nv_load) begin
      n.ofs     = nv_offset_coef;
      n.gain    = nv_gain_coef;
      n.nv_load = 1'b0;
    end

    // busy covers the whole calibration run
    if (r.cal_start) begin
      if (r.cal_cnt == CAL_CYCLES - 11'h001) begin
        n.cal_start = 1'b0;
        n.cal_cnt   = '0;
      end else begin
        n.cal_cnt = r.cal_cnt + 11'h001;
      end
    end

    n.cap_dis = n.cs[CS_CAP_BIT];

    // undefined if several methods enabled; any one starts it
    start_req = r.cs[CS_SINGLE_BIT] | r.cs[CS_CONT_BIT]
              | (r.tt[TT_EXT_BIT] & ext_rise)
              | (r.tt[TT_TMR_BIT] & timer2_overflow);

    case (r.st)
      ST_IDLE: begin
        if (start_req && !r.cal_start && !r.nv_load) begin
          n.st    = ST_SYNC;
          n.armed = 1'b0;
          n.ch    = r.cs[CS_CH_LSB +: 4];
        end
      end
      ST_SYNC: begin
        // wait for a falling then a rising converter edge
        if (fall_tick) n.armed = 1'b1;
        if (rise_tick && r.armed) begin
          n.st     = ST_ACQ;
          n.ph_cnt = 4'h0;
          n.sample = 1'b1;
        end
      end
      ST_ACQ: begin
        // edge triggers arriving here are dropped
        if (rise_tick) begin
          if (r.ph_cnt == {2'h0, eff_acq}) begin
            n.st     = ST_CONV;
            n.ph_cnt = 4'h0;
            n.sample = 1'b0;
            n.hold   = 1'b1;
          end else begin
            n.ph_cnt = r.ph_cnt + 4'h1;
          end
        end
      end
      ST_CONV: begin
        if (rise_tick) begin
          if (r.ph_cnt == CONV_LAST) begin
            n.res    = conv_data;
            n.res_ch = r.ch;
            n.done   = 1'b1;
            // unread result overwritten
            if (r.done && !(wr_go && n.aw_addr == ADDR_STATUS
                            && n.w_strb[0] && n.w_data[ST_DONE_BIT])) begin
              n.lost = 1'b1;
            end
            if (r.cs[CS_CAP_BIT]) begin
              if (shift_busy) begin
                n.lost = 1'b1;
              end else begin
                n.cap_load = 1'b1;
                n.cap_data = {r.ch, conv_data};
              end
            end
            if (!wr_single) n.cs[CS_SINGLE_BIT] = 1'b0;
            n.hold   = 1'b0;
            n.ph_cnt = 4'h0;
            if (n.cs[CS_CONT_BIT]) begin
              n.st     = ST_ACQ;
              n.sample = 1'b1;
              n.ch     = n.cs[CS_CH_LSB +: 4];
            end else begin
              n.st = ST_IDLE;
            end
          end else begin
            n.ph_cnt = r.ph_cnt + 4'h1;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r           <= '0;
      r.st        <= ST_IDLE;
      r.tt        <= TT_RST;
      r.cs        <= CS_RST;
      r.ofs       <= COEF_RST;
      r.gain      <= COEF_RST;
      r.nv_load   <= 1'b1;
      r.ext_s1    <= 1'b1;
      r.ext_s2    <= 1'b1;
      r.ext_s3    <= 1'b1;
      r.awready   <= 1'b1;
      r.wready    <= 1'b1;
      r.arready   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // serial data register and shifter for capture mode
  adcseq_shift u_shift (
    .clock   (clock),
    .rst_n   (rst_n),
    .enable  (r.cap_dis),
    .load    (r.cap_load),
    .data    (r.cap_data),
    .busy    (shift_busy),
    .sclk    (serial_sclk),
    .mosi    (serial_mosi),
    .frame_n (serial_frame_n)
  );

  assign s_axi_awready         = r.awready;
  assign s_axi_wready          = r.wready;
  assign s_axi_bvalid          = r.bvalid;
  assign s_axi_bresp           = r.bresp;
  assign s_axi_arready         = r.arready;
  assign s_axi_rvalid          = r.rvalid;
  assign s_axi_rdata           = r.rdata;
  assign s_axi_rresp           = r.rresp;
  assign converter_clock       = r.cclk;
  assign conv_sample           = r.sample;
  assign conv_hold             = r.hold;
  assign conv_channel          = r.ch;
  assign cal_active            = r.cal_start;
  assign cal_offset            = r.ofs;
  assign cal_gain              = r.gain;
  assign serial_normal_disable = r.cap_dis;
  assign port3_disable         = r.cap_dis;

endmodule // adcseq_top

/* File: verif/adcseq_properties.sv */
`timescale 1ns/1ps
module adcseq_properties
  import adcseq_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        converter_clock,
  input wire logic        conv_sample,
  input wire logic        conv_hold,
  input wire logic [3:0]  conv_channel,
  input wire logic [13:0] cal_offset,
  input wire logic [13:0] cal_gain,
  input wire logic [13:0] nv_offset_coef,
  input wire logic [13:0] nv_gain_coef,
  input wire logic        serial_normal_disable,
  input wire logic        port3_disable,
  input wire logic        serial_sclk,
  input wire logic        serial_mosi,
  input wire logic        serial_frame_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [4:0] acq_cnt_r;
  logic [4:0] hold_cnt_r;
  logic [6:0] frm_cnt_r;
  logic [1:0] cyc_r;
  // tick that closes a phase lands after it, so count equals periods
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acq_cnt_r  <= 5'h0;
      hold_cnt_r <= 5'h0;
      frm_cnt_r  <= 7'h0;
      cyc_r      <= 2'h0;
    end else begin
      acq_cnt_r  <= conv_sample ?
                    acq_cnt_r + 5'($rose(converter_clock)) : 5'h0;
      hold_cnt_r <= conv_hold ?
                    hold_cnt_r + 5'($rose(converter_clock)) : 5'h0;
      frm_cnt_r  <= serial_frame_n ? 7'h0 : frm_cnt_r + 7'h1;
      cyc_r      <= cyc_r + 2'(cyc_r != 2'h3);
    end
  end
  a_acq_len: assert property ($fell(conv_sample) |->
    conv_hold && acq_cnt_r inside {[5'h1:5'h4]}) else $error("bad acq");
  a_conv_len: assert property ($fell(conv_hold) |->
    hold_cnt_r == 5'hf) else $error("bad conversion length");
  a_temp_acq: assert property ($fell(conv_sample) &&
    conv_channel == TEMP_CHANNEL |-> acq_cnt_r == 5'h4) else $error("temp acq");
  a_temp_clk: assert property ($rose(converter_clock) && conv_hold &&
    conv_channel == TEMP_CHANNEL |-> converter_clock [*8] ##8
    converter_clock ##1 !converter_clock) else $error("temp divider");
  a_cal_load: assert property (cyc_r == 2'h1 |->
    cal_offset == nv_offset_coef && cal_gain == nv_gain_coef)
    else $error("coefficients not loaded");
  a_cap_off: assert property (!serial_normal_disable |=>
    serial_frame_n) else $error("transfer without capture");
  a_ports_tied: assert property (serial_normal_disable ==
    port3_disable) else $error("port disables differ");
  a_frame_len: assert property ($rose(serial_frame_n) &&
    serial_normal_disable |-> frm_cnt_r == 7'h40) else $error("frame length");
  a_sclk_idle: assert property (serial_frame_n |->
    !serial_sclk) else $error("clock outside frame");
  a_mosi_hold: assert property (!serial_frame_n && serial_sclk |->
    $stable(serial_mosi)) else $error("data moved while clock high");
  c_frame: cover property ($fell(serial_frame_n));
  c_temp: cover property (conv_hold && conv_channel == TEMP_CHANNEL);
  c_conv: cover property ($fell(conv_hold));
endmodule // adcseq_properties

bind adcseq_top adcseq_properties i_props (
  .clock(clock), .rst_n(rst_n), .converter_clock(converter_clock),
  .conv_sample(conv_sample), .conv_hold(conv_hold),
  .conv_channel(conv_channel), .cal_offset(cal_offset),
  .cal_gain(cal_gain), .nv_offset_coef(nv_offset_coef),
  .nv_gain_coef(nv_gain_coef), .serial_normal_disable(serial_normal_disable),
  .port3_disable(port3_disable), .serial_sclk(serial_sclk),
  .serial_mosi(serial_mosi), .serial_frame_n(serial_frame_n)
);

/* File: verif/adcseq_rx_model.sv */
`timescale 1ns/1ps
module adcseq_rx_model (
  input  wire logic   clock,
  input  wire logic   rst_n,
  input  wire logic   sclk,
  input  wire logic   mosi,
  input  wire logic   frame_n,
  output logic [15:0] word,
  output int          words
);
  logic [15:0] sh;
  logic        sclk_q;
  int          nb;
  // aborted frames are dropped, a short word is never reported
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sh <= 16'h0;
      sclk_q <= 1'b0;
      nb <= 0;
      word <= 16'h0;
      words <= 0;
    end else begin
      sclk_q <= sclk;
      if (!frame_n && sclk && !sclk_q) begin
        sh <= {sh[14:0], mosi};
        nb <= nb + 1;
      end else if (frame_n) begin
        nb <= 0;
        if (nb == 16) begin
          word <= sh;
          words <= words + 1;
        end
      end
    end
  end
endmodule // adcseq_rx_model

/* File: verif/adc_conversion_sequencer_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); \
  end \
end
module adc_conversion_sequencer_test
  import adcseq_pkg::*;
;
  logic        clock = 1'b0, rst_n = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        external_convert_strobe_n = 1'b1, timer2_overflow = 1'b0;
  logic [11:0] conv_data = 12'h0;
  logic [13:0] nv_offset_coef = 14'h1a5c, nv_gain_coef = 14'h2b3d;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, converter_clock, conv_sample, conv_hold;
  logic        cal_active, serial_normal_disable, port3_disable, seen;
  logic        serial_sclk, serial_mosi, serial_frame_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [3:0]  conv_channel, ch;
  logic [13:0] cal_offset, cal_gain;
  logic [15:0] rx_word;
  int          rx_words, n0, ts, ta, tc, k, num_errors = 0, n_compared = 0;
  int          dv[5] = '{8, 4, 16, 32, 32};
  int          aq[5] = '{4, 1, 2, 3, 4};
  logic [7:0]  tt[5] = '{8'h0c, 8'h10, 8'h24, 8'h38, 8'h10};

  always #2.5 clock = ~clock;
  adcseq_top i_dut (.*);
  adcseq_rx_model i_rx (.clock(clock), .rst_n(rst_n), .sclk(serial_sclk),
    .mosi(serial_mosi), .frame_n(serial_frame_n), .word(rx_word),
    .words(rx_words));

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    @(posedge clock);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse(input int m);
    @(posedge clock);
    if (m == 0) begin
      external_convert_strobe_n <= 1'b0;
      repeat (STROBE_LOW_CYCLES) @(posedge clock);
      external_convert_strobe_n <= 1'b1;
    end else begin
      timer2_overflow <= 1'b1;
      @(posedge clock);
      timer2_overflow <= 1'b0;
    end
  endtask

  task automatic meas();
    ts = 0;
    ta = 0;
    tc = 0;
    while (conv_sample !== 1'b1 && ts < 2000) begin
      @(posedge clock);
      ts++;
    end
    while (conv_sample === 1'b1) begin
      @(posedge clock);
      ta++;
    end
    while (conv_hold === 1'b1) begin
      @(posedge clock);
      tc++;
    end
  endtask

  task automatic quiet(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(posedge clock);
      seen |= conv_sample;
    end
  endtask

  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #100_000;
    num_errors++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK({cal_offset, cal_gain}, {nv_offset_coef, nv_gain_coef})
    rd(ADDR_CALGAIN);
    `CHK(d, {18'h0, nv_gain_coef})
    rd(ADDR_TIMING);
    `CHK(d[7:0], TT_RST)
    rd(8'h1c);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(8'h1c, 32'h0, RESP_SLVERR);
    wr(ADDR_CALCTL, 32'h1, RESP_OKAY);
    rd(ADDR_CALCTL);
    `CHK({d[CAL_BUSY_BIT], cal_active}, 2'b11)
    k = 0;
    while (d[CAL_BUSY_BIT] === 1'b1 && k < 2000) begin
      rd(ADDR_CALCTL);
      k++;
    end
    `CHK(k > int'(CAL_CYCLES) / 4 && k < 2000, 1'b1)
    // temperature case last: same timing word must be overridden
    for (int i = 0; i < 5; i++) begin
      ch = (i == 4) ? TEMP_CHANNEL : 4'(i);
      conv_data <= 12'h5a0 + 12'(i);
      wr(ADDR_TIMING, {24'h0, tt[i]}, RESP_OKAY);
      wr(ADDR_CHANCTL, 32'h20 | 32'(ch), RESP_OKAY);
      meas();
      `CHK(ta, aq[i] * dv[i])
      `CHK(tc, 15 * dv[i])
      `CHK(ts >= dv[i] / 2 - 2 && ts <= 3 * dv[i] / 2 + 3, 1'b1)
      rd(ADDR_STATUS);
      `CHK(d[ST_DONE_BIT], 1'b1)
      rd(ADDR_RESULT);
      `CHK(d[15:0], {ch, 12'h5a0 + 12'(i)})
      rd(ADDR_CHANCTL);
      `CHK(d[CS_SINGLE_BIT], 1'b0)
      wr(ADDR_STATUS, 32'h3, RESP_OKAY);
    end
    wr(ADDR_CHANCTL, 32'h11, RESP_OKAY);
    meas();
    meas();
    `CHK(ts <= 1, 1'b1)
    wr(ADDR_CHANCTL, 32'h1, RESP_OKAY);
    meas();
    quiet(200);
    `CHK(seen, 1'b0)
    rd(ADDR_STATUS);
    `CHK(d[ST_LOST_BIT], 1'b1)
    wr(ADDR_STATUS, 32'h3, RESP_OKAY);
    // one trigger source enabled at a time, pulsed with the other too
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_TIMING, 32'h10 | (32'h1 << (m < 2 ? m : 3 - m)), 2'h0);
      pulse(m % 2);
      quiet(120);
      `CHK(seen, m < 2)
      quiet(20);
    end
    wr(ADDR_TIMING, 32'h12, RESP_OKAY);
    wr(ADDR_CHANCTL, 32'h45, RESP_OKAY);
    repeat (2) @(posedge clock);
    `CHK({serial_normal_disable, port3_disable}, 2'b11)
    n0 = rx_words;
    for (int j = 0; j < 2; j++) begin
      conv_data <= 12'habc + 12'(j);
      pulse(1);
      repeat (80) @(posedge clock);
    end
    k = 0;
    while (rx_words < n0 + 2 && k < 300) begin
      @(posedge clock);
      k++;
    end
    `CHK(rx_words - n0, 2)
    `CHK(rx_word, 16'h5abd)
    // pipelined stream: 68-cycle conversions, each shift overlaps the next
    wr(ADDR_TIMING, 32'h14, RESP_OKAY);
    conv_data <= 12'h123;
    wr(ADDR_CHANCTL, 32'h54, RESP_OKAY);
    n0 = rx_words;
    k = 0;
    while (rx_words < n0 + 3 && k < 1000) begin
      @(posedge clock);
      k++;
    end
    // three back-to-back words; a dropped one pushes this past 340
    `CHK(k < 340, 1'b1)
    `CHK(rx_word, 16'h4123)
    wr(ADDR_CHANCTL, 32'h5, RESP_OKAY);
    repeat (2) @(posedge clock);
    `CHK({serial_normal_disable, port3_disable}, 2'b00)
    repeat (80) @(posedge clock);
    n0 = rx_words;
    wr(ADDR_TIMING, 32'h12, RESP_OKAY);
    pulse(1);
    quiet(150);
    `CHK(seen, 1'b1)
    `CHK(rx_words - n0, 0)
    final_report();
  end
endmodule // adc_conversion_sequencer_test
